/* common/pdc_pkg.sv */
// Package for the loop divider configuration block: register map, field
// positions, reset values.
// Assumes a byte-wide register port with a 4-bit word address.
package pdc_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [3:0] ADDR_LOOP_CTRL  = 4'h0;
  localparam logic [3:0] ADDR_BANDWIDTH  = 4'h1;
  localparam logic [3:0] ADDR_RANGE_MULT = 4'h2;
  localparam logic [3:0] ADDR_REF_DIV    = 4'h3;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_IE_BIT   = 7;
  localparam int CTRL_FLAG_BIT = 6;
  localparam int CTRL_ON_BIT   = 5;
  localparam int CTRL_BCS_BIT  = 4;
  localparam int BW_AUTO_BIT   = 7;
  localparam int BW_LOCK_BIT   = 6;
  localparam int REF_DIV_W     = 4;

  // ----------------------------------------------------------------------
  // Reset values and fixed constants
  // ----------------------------------------------------------------------
  localparam logic [7:0]           RANGE_MULT_RST = 8'h40;
  localparam logic [REF_DIV_W-1:0] REF_DIV_RST    = 4'h1;
  localparam logic [REF_DIV_W-1:0] REF_DIV_ONE    = 4'h1;
  localparam logic [7:0]           RANGE_ZERO     = 8'h00;
  localparam logic                 LOOP_ON_RST    = 1'b1;

endpackage : pdc_pkg

/* verilog/pdc_lock_sync.sv */
// Three-stage synchroniser for the analog lock indicator, with change pulse.
// Assumes the input is asynchronous to clk_sys_i; a change is taken once
// the second and third stages agree.
module pdc_lock_sync (
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  input  wire logic async_i,
  output logic      level_o,
  output logic      change_o
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic ff1;
    logic ff2;
    logic ff3;
    logic level;
    logic change;
  } pdc_sync_t;

  pdc_sync_t s_q;
  pdc_sync_t s_d;

  always_comb begin
    s_d        = s_q;
    s_d.ff1    = async_i;
    s_d.ff2    = s_q.ff1;
    s_d.ff3    = s_q.ff2;
    s_d.change = 1'b0;
    // Agreement of two stages filters a metastable settle on stage two
    if ((s_q.ff2 == s_q.ff3) && (s_q.ff3 != s_q.level)) begin
      s_d.level  = s_q.ff3;
      s_d.change = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign level_o  = s_q.level;
  assign change_o = s_q.change;

endmodule : pdc_lock_sync

/* verilog/pdc_pll_ctrl.sv */
// Register and mode control for a clock generator phase-locked loop.
// Assumes a same-clock register master, and stop, break and oscillator
// option inputs driven by logic on clk_sys_i; only lock_i is asynchronous.
//
// The register addresses and the strobed register port are this design's own decisions.
module pdc_pll_ctrl (
  input  wire logic       clk_sys_i,
  input  wire logic       resetn_i,
  input  wire logic [3:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  input  wire logic       lock_i,
  input  wire logic       stop_i,
  input  wire logic       osc_stop_en_i,
  input  wire logic       break_i,
  input  wire logic       break_flag_clear_en_i,
  output logic            loop_enable_o,
  output logic            osc_enable_o,
  output logic            crystal_clock_en_o,
  output logic            vco_clock_sel_o,
  output logic            out_clk_o,
  output logic      [7:0] range_mult_o,
  output logic      [3:0] ref_div_o,
  output logic            irq_o
);

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------------
  // Lock indicator crossing
  // ----------------------------------------------------------------------
  logic lock_level;
  logic lock_chg;

  pdc_lock_sync u_lock_sync (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n),
    .async_i   (lock_i),
    .level_o   (lock_level),
    .change_o  (lock_chg)
  );

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic                          loop_interrupt_enable;
    logic                          loop_interrupt_flag;
    logic                          loop_on;
    logic                          base_clock_source_select;
    logic                          auto_mode;
    logic [7:0]                    range_multiplier_field;
    logic [pdc_pkg::REF_DIV_W-1:0] reference_division_field;
    logic [7:0]                    rdata;
    logic                          out_clk;
  } pdc_state_t;

  pdc_state_t s_q;
  pdc_state_t s_d;

  function automatic logic hit(input logic [3:0] addr, input logic [3:0] reg_addr);
    hit = (addr == reg_addr);
  endfunction : hit

  logic wr_ctrl;
  logic wr_bw;
  logic wr_range;
  logic wr_ref;
  logic rd_ctrl;
  logic flag_guard;
  logic flag_set;
  logic flag_clr;
  logic halt_all;
  logic range_zero;
  logic [7:0] ctrl_view;
  logic [7:0] bw_view;

  assign wr_ctrl    = reg_wr_i && hit(reg_addr_i, pdc_pkg::ADDR_LOOP_CTRL);
  assign wr_bw      = reg_wr_i && hit(reg_addr_i, pdc_pkg::ADDR_BANDWIDTH);
  assign wr_range   = reg_wr_i && hit(reg_addr_i, pdc_pkg::ADDR_RANGE_MULT);
  assign wr_ref     = reg_wr_i && hit(reg_addr_i, pdc_pkg::ADDR_REF_DIV);
  assign rd_ctrl    = reg_rd_i && hit(reg_addr_i, pdc_pkg::ADDR_LOOP_CTRL);
  assign flag_guard = break_i && !break_flag_clear_en_i;
  assign range_zero = (s_q.range_multiplier_field == pdc_pkg::RANGE_ZERO);
  assign halt_all   = stop_i && !osc_stop_en_i;

  // Set wins over a read clear in the same cycle so no lock edge is lost
  assign flag_set = s_q.auto_mode && lock_chg;
  assign flag_clr = rd_ctrl && !flag_guard;

  // ----------------------------------------------------------------------
  // Read views
  // ----------------------------------------------------------------------
  always_comb begin
    ctrl_view = 8'h00;
    ctrl_view[pdc_pkg::CTRL_IE_BIT]   = s_q.loop_interrupt_enable && s_q.auto_mode;
    ctrl_view[pdc_pkg::CTRL_FLAG_BIT] = s_q.loop_interrupt_flag && s_q.auto_mode;
    ctrl_view[pdc_pkg::CTRL_ON_BIT]   = s_q.loop_on;
    ctrl_view[pdc_pkg::CTRL_BCS_BIT]  = s_q.base_clock_source_select;
    bw_view = 8'h00;
    bw_view[pdc_pkg::BW_AUTO_BIT]     = s_q.auto_mode;
    bw_view[pdc_pkg::BW_LOCK_BIT]     = lock_level && s_q.auto_mode;
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_d = s_q;

    s_d.loop_interrupt_flag = flag_set || (s_q.loop_interrupt_flag && !flag_clr);

    if (wr_ctrl) begin
      // Enable is only writable in automatic mode
      if (s_q.auto_mode) begin
        s_d.loop_interrupt_enable = reg_wdata_i[pdc_pkg::CTRL_IE_BIT];
      end
      // Loop stays on while the VCO drives the output
      if (!s_q.base_clock_source_select) begin
        s_d.loop_on = reg_wdata_i[pdc_pkg::CTRL_ON_BIT];
      end
      // Lock is not required to select the VCO, only loop on, a non-zero range and no stop
      s_d.base_clock_source_select = reg_wdata_i[pdc_pkg::CTRL_BCS_BIT]
                                     && s_q.loop_on && !range_zero;
    end

    if (wr_bw) begin
      s_d.auto_mode = reg_wdata_i[pdc_pkg::BW_AUTO_BIT];
    end

    if (wr_range && !s_q.loop_on) begin
      s_d.range_multiplier_field = reg_wdata_i;
    end

    if (wr_ref && !s_q.loop_on) begin
      s_d.reference_division_field = reg_wdata_i[pdc_pkg::REF_DIV_W-1:0];
    end

    // A zero range can only be written with the loop off, but guard anyway
    if (range_zero) begin
      s_d.base_clock_source_select = 1'b0;
    end

    // Stop falls back to the crystal; only a control write sets the bit again afterward
    if (stop_i) begin
      s_d.base_clock_source_select = 1'b0;
    end

    s_d.rdata = 8'h00;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        pdc_pkg::ADDR_LOOP_CTRL:  s_d.rdata = ctrl_view;
        pdc_pkg::ADDR_BANDWIDTH:  s_d.rdata = bw_view;
        pdc_pkg::ADDR_RANGE_MULT: s_d.rdata = s_q.range_multiplier_field;
        pdc_pkg::ADDR_REF_DIV: begin
          s_d.rdata = {4'h0, s_q.reference_division_field};
        end
        default:                  s_d.rdata = 8'h00;
      endcase
    end

    // Output clock divides clk_sys_i by two whatever the source select; only stop
    // with osc_stop_en_i low, never wait, affects it
    if (halt_all) begin
      s_d.out_clk = 1'b0;
    end else begin
      s_d.out_clk = !s_q.out_clk;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      s_q                          <= '0;
      s_q.loop_on                  <= pdc_pkg::LOOP_ON_RST;
      s_q.range_multiplier_field   <= pdc_pkg::RANGE_MULT_RST;
      s_q.reference_division_field <= pdc_pkg::REF_DIV_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Loop runs only with loop on, a non-zero range and outside stop
  assign loop_enable_o      = s_q.loop_on && !range_zero && !stop_i;
  assign osc_enable_o       = !halt_all;
  assign crystal_clock_en_o = !halt_all;
  assign vco_clock_sel_o    = s_q.base_clock_source_select;
  assign out_clk_o          = s_q.out_clk;
  assign range_mult_o       = s_q.range_multiplier_field;
  assign ref_div_o          = (s_q.reference_division_field == '0) ?
                              pdc_pkg::REF_DIV_ONE : s_q.reference_division_field;
  assign irq_o              = s_q.loop_interrupt_flag && s_q.loop_interrupt_enable
                              && s_q.auto_mode && !halt_all;
  assign reg_rdata_o        = s_q.rdata;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_range_write_lock: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n)
    (wr_range && s_q.loop_on) |=> $stable(s_q.range_multiplier_field))
    else $error("range multiplier changed while loop on");

  a_zero_range_off: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n)
    range_zero |-> (!loop_enable_o && !vco_clock_sel_o))
    else $error("zero range left loop or vco select active");

  a_select_needs_range: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n)
    (wr_ctrl && range_zero) |=> !s_q.base_clock_source_select)
    else $error("source select set with zero range");

  a_refdiv_write_lock: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n)
    (wr_ref && s_q.loop_on) |=> $stable(s_q.reference_division_field))
    else $error("reference divider changed while loop on");

  a_refdiv_zero_one: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n)
    (s_q.reference_division_field == '0) |-> (ref_div_o == pdc_pkg::REF_DIV_ONE))
    else $error("zero divider not treated as one");

  a_refdiv_upper_zero: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n)
    (reg_rd_i && hit(reg_addr_i, pdc_pkg::ADDR_REF_DIV)) |=> (reg_rdata_o[7:4] == 4'h0))
    else $error("reference divider upper bits not zero");

  a_lock_sets_flag: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n)
    (s_q.auto_mode && lock_chg) |=> s_q.loop_interrupt_flag)
    else $error("lock change did not set flag");

  // Pin and register view must agree: a raised request reads back as flag and enable
  a_irq_gating: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n)
    (rd_ctrl && irq_o) |=> (reg_rdata_o[pdc_pkg::CTRL_IE_BIT]
                            && reg_rdata_o[pdc_pkg::CTRL_FLAG_BIT]))
    else $error("interrupt request does not follow flag and enable");

  a_read_clears_flag: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n)
    (rd_ctrl && !flag_guard && !flag_set) |=> !s_q.loop_interrupt_flag)
    else $error("control read did not clear flag");

  a_break_keeps_flag: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n)
    (flag_guard && s_q.loop_interrupt_flag) |=> s_q.loop_interrupt_flag)
    else $error("flag lost during protected break");

  a_stop_halts_clk: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n)
    halt_all [*2] |-> (!out_clk_o && !osc_enable_o && !irq_o && !crystal_clock_en_o))
    else $error("outputs active during stop");

  a_stop_clears_sel: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n)
    stop_i |=> !vco_clock_sel_o)
    else $error("source select survived stop entry");

  a_loop_on_kept: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n)
    s_q.base_clock_source_select |=> s_q.loop_on)
    else $error("loop turned off while vco selected");

  // The first edge after release still holds the reset value, so skip it
  a_out_clk_halves: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n)
    ((rst_n && !halt_all) ##1 !halt_all) |-> (out_clk_o != $past(out_clk_o)))
    else $error("output clock not toggling at half rate");

  // Sampled at release, before any register can have moved
  a_reset_values: assert property (
    @(posedge clk_sys_i)
    $rose(rst_n) |-> ((range_mult_o == pdc_pkg::RANGE_MULT_RST)
                      && (s_q.reference_division_field == pdc_pkg::REF_DIV_RST)))
    else $error("range or divider not at reset value");

  a_flag_without_ie: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n)
    (s_q.auto_mode && lock_chg && !s_q.loop_interrupt_enable) |=> s_q.loop_interrupt_flag)
    else $error("flag not set with enable clear");

  a_manual_flag_zero: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n)
    (rd_ctrl && !s_q.auto_mode) |=> (reg_rdata_o[pdc_pkg::CTRL_FLAG_BIT] == 1'b0))
    else $error("flag visible in manual mode");

  a_manual_ie_kept: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n)
    (wr_ctrl && !s_q.auto_mode) |=> $stable(s_q.loop_interrupt_enable))
    else $error("interrupt enable written in manual mode");

  a_select_unlocked: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n)
    (wr_ctrl && reg_wdata_i[pdc_pkg::CTRL_BCS_BIT] && s_q.loop_on && !range_zero
     && !stop_i && !lock_level) |=> s_q.base_clock_source_select)
    else $error("source select refused without lock");

  a_stop_osc_kept: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n)
    (stop_i && osc_stop_en_i) |-> (osc_enable_o && crystal_clock_en_o && !loop_enable_o))
    else $error("oscillator option not honoured in stop");

  a_break_clear_kept: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n)
    (break_i && break_flag_clear_en_i && rd_ctrl && !flag_set) |=> !s_q.loop_interrupt_flag)
    else $error("flag not cleared by read in open break");

endmodule : pdc_pll_ctrl

/* verification/tb_top.sv */
// Self-checking bench for the loop divider configuration block.
// Assumes the design package is compiled first; no partner model is used.
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
  $display("MISMATCH %s exp %h got %h", nm, e, g); err_count++; end end
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic       clk_sys_i = 1'b0;
  logic       resetn_i = 1'b0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic       reg_wr_i = 1'b0;
  logic       reg_rd_i = 1'b0;
  logic       lock_i = 1'b0;
  logic       stop_i = 1'b0;
  logic       osc_stop_en_i = 1'b0;
  logic       break_i = 1'b0;
  logic       bfce_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic       loop_enable_o, osc_enable_o, crystal_clock_en_o;
  logic       vco_clock_sel_o, out_clk_o, irq_o;
  logic [7:0] range_mult_o;
  logic [3:0] ref_div_o;
  logic [7:0] exp_q[$];
  string      nm_q[$];
  string      w_nm;
  logic [7:0] w_exp;
  logic       rd_pend = 1'b0;
  logic [31:0] seed = 32'h1e3b;
  logic       oc;
  int         err_count = 0;
  int         num_checks = 0;
  localparam logic [3:0] C = pdc_pkg::ADDR_LOOP_CTRL;
  localparam logic [3:0] B = pdc_pkg::ADDR_BANDWIDTH;
  localparam logic [3:0] R = pdc_pkg::ADDR_RANGE_MULT;
  localparam logic [3:0] D = pdc_pkg::ADDR_REF_DIV;
  always #2 clk_sys_i = ~clk_sys_i;
  pdc_pll_ctrl DUT (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .lock_i(lock_i), .stop_i(stop_i),
    .osc_stop_en_i(osc_stop_en_i), .break_i(break_i),
    .break_flag_clear_en_i(bfce_i), .loop_enable_o(loop_enable_o),
    .osc_enable_o(osc_enable_o), .crystal_clock_en_o(crystal_clock_en_o),
    .vco_clock_sel_o(vco_clock_sel_o), .out_clk_o(out_clk_o),
    .range_mult_o(range_mult_o), .ref_div_o(ref_div_o), .irq_o(irq_o)
  );
  // ----------------------------------------------------------------------
  // Read data watcher: oldest note is compared in the cycle after a read
  // ----------------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    if (rd_pend) begin
      // Pop once: the macro names its arguments more than once
      w_nm  = nm_q.pop_front();
      w_exp = exp_q.pop_front();
      `CHK(w_nm, w_exp, reg_rdata_o)
    end
    rd_pend <= reg_rd_i;
  end
  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : cyc
  // A gap cycle after each strobe keeps one assignment per signal per step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    cyc(1);
    reg_wr_i    <= 1'b0;
    cyc(1);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
    exp_q.push_back(e);
    nm_q.push_back(nm);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    cyc(1);
    reg_rd_i   <= 1'b0;
    cyc(1);
  endtask : rd
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim
  task automatic wait_irq;
    int i;
    for (i = 0; i < 20 && irq_o !== 1'b1; i++) @(negedge clk_sys_i);
    if (irq_o !== 1'b1) begin
      $display("MISMATCH irq_o exp 1 got %b", irq_o);
      err_count++;
      end_sim();
    end else begin
      cyc(1);
    end
  endtask : wait_irq
  task automatic tend(input string nm);
    $display("test %s done", nm);
  endtask : tend
  initial begin
    #40000;
    $display("MISMATCH run timeout");
    err_count++;
    end_sim();
  end
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    cyc(12);
    resetn_i <= 1'b1;
    cyc(3);
    rd(C, 8'h20, "ctrl rst");
    rd(B, 8'h00, "bw rst");
    rd(R, 8'h40, "range rst");
    rd(D, 8'h01, "refdiv rst");
    rd(4'h9, 8'h00, "unmapped");
    tend("reset");
    seed = lfsr(seed);
    wr(R, seed[7:0]);
    wr(D, seed[15:8]);
    wr(4'h9, 8'hff);
    rd(R, 8'h40, "range locked");
    rd(D, 8'h01, "refdiv locked");
    tend("locked writes");
    wr(C, 8'h00);
    seed = lfsr(seed);
    wr(R, seed[7:0] | 8'h01);
    wr(D, seed[15:8]);
    rd(R, seed[7:0] | 8'h01, "range wr");
    rd(D, {4'h0, seed[11:8]}, "refdiv wr");
    wr(D, 8'hf0);
    rd(D, 8'h00, "refdiv upper");
    #1 `CHK("ref_div_o", 4'h1, ref_div_o)
    `CHK("range_mult_o", seed[7:0] | 8'h01, range_mult_o)
    cyc(1);
    wr(R, 8'h40);
    wr(D, 8'h01);
    tend("unlocked writes");
    wr(C, 8'h10);
    rd(C, 8'h00, "sel needs on");
    wr(C, 8'h20);
    wr(C, 8'h30);
    rd(C, 8'h30, "sel unlocked");
    wr(C, 8'h00);
    rd(C, 8'h20, "on held");
    wr(C, 8'h00);
    wr(R, 8'h00);
    wr(C, 8'h20);
    wr(C, 8'h30);
    rd(C, 8'h20, "sel range0");
    #1 `CHK("loop_en r0", 1'b0, loop_enable_o)
    `CHK("vco_sel r0", 1'b0, vco_clock_sel_o)
    cyc(1);
    wr(C, 8'h00);
    wr(R, 8'h40);
    wr(C, 8'h20);
    #1 `CHK("loop_en", 1'b1, loop_enable_o)
    cyc(1);
    tend("select protect");
    wr(B, 8'h80);
    wr(C, 8'ha0);
    lock_i <= 1'b1;
    wait_irq();
    cyc(4);
    #1 `CHK("irq held", 1'b1, irq_o)
    cyc(1);
    rd(C, 8'he0, "flag set");
    rd(C, 8'ha0, "flag read clr");
    rd(B, 8'hc0, "bw locked");
    #1 `CHK("irq clr", 1'b0, irq_o)
    cyc(1);
    wr(C, 8'h20);
    lock_i <= 1'b0;
    cyc(8);
    #1 `CHK("irq no ie", 1'b0, irq_o)
    cyc(1);
    rd(C, 8'h60, "flag no ie");
    rd(C, 8'h20, "flag clr2");
    tend("lock irq");
    break_i <= 1'b1;
    lock_i  <= 1'b1;
    cyc(8);
    rd(C, 8'h60, "brk rd");
    wr(C, 8'h20);
    rd(C, 8'h60, "brk kept");
    bfce_i <= 1'b1;
    rd(C, 8'h60, "brk clr rd");
    rd(C, 8'h20, "brk cleared");
    break_i <= 1'b0;
    bfce_i  <= 1'b0;
    rd(C, 8'h20, "after brk");
    tend("break");
    wr(C, 8'ha0);
    lock_i <= 1'b0;
    cyc(8);
    wr(B, 8'h00);
    #1 `CHK("irq manual", 1'b0, irq_o)
    cyc(1);
    wr(B, 8'h80);
    #1 `CHK("irq stored", 1'b1, irq_o)
    cyc(1);
    wr(B, 8'h00);
    rd(C, 8'h20, "ctrl manual");
    rd(B, 8'h00, "bw manual");
    wr(B, 8'h80);
    wr(C, 8'hb0);
    #1 `CHK("vco_sel", 1'b1, vco_clock_sel_o)
    @(negedge clk_sys_i) oc = out_clk_o;
    @(negedge clk_sys_i) `CHK("out_clk half", ~oc, out_clk_o)
    cyc(1);
    tend("manual mode");
    // Raise the flag so that the halt check below has a request to drop
    lock_i <= 1'b1;
    cyc(8);
    stop_i        <= 1'b1;
    osc_stop_en_i <= 1'b1;
    cyc(2);
    #1 `CHK("stop sel", 1'b0, vco_clock_sel_o)
    `CHK("stop loop", 1'b0, loop_enable_o)
    `CHK("stop osc on", 1'b1, osc_enable_o)
    `CHK("stop xclk on", 1'b1, crystal_clock_en_o)
    `CHK("stop irq on", 1'b1, irq_o)
    cyc(1);
    osc_stop_en_i <= 1'b0;
    cyc(2);
    #1 `CHK("halt osc", 1'b0, osc_enable_o)
    `CHK("halt xclk", 1'b0, crystal_clock_en_o)
    `CHK("halt irq", 1'b0, irq_o)
    `CHK("halt out", 1'b0, out_clk_o)
    @(negedge clk_sys_i) `CHK("halt out2", 1'b0, out_clk_o)
    cyc(1);
    stop_i <= 1'b0;
    cyc(2);
    rd(C, 8'he0, "sel after stop");
    tend("stop");
    cyc(2);
    `CHK("queue empty", 0, exp_q.size())
    end_sim();
  end
endmodule : tb_top
